// ### design/pin_edge_detect.sv
// Two-flop pin synchroniser with rising and falling edge detection
`timescale 1ns/1ps
module pin_edge_detect
  import port_pins_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Thresholded pin levels from the pads
  input wire logic [NPINS-1:0] pin_st,
  input wire logic [NPINS-1:0] pin_ttl,
  input wire logic [NPINS-1:0] thresh_sel,
  // Sampled level and edges
  output logic [NPINS-1:0] level,
  output logic [NPINS-1:0] rise,
  output logic [NPINS-1:0] fall
);
  logic [NPINS-1:0] st_meta_reg;
  logic [NPINS-1:0] st_sync_reg;
  logic [NPINS-1:0] ttl_meta_reg;
  logic [NPINS-1:0] ttl_sync_reg;
  logic [NPINS-1:0] prev_reg;
  logic [2:0] warm_reg;
  wire [NPINS-1:0] pick;
  wire primed;

  // Both pad thresholds cross into the clock domain before any logic reads them
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      st_meta_reg <= 4'h0;
      st_sync_reg <= 4'h0;
      ttl_meta_reg <= 4'h0;
      ttl_sync_reg <= 4'h0;
      prev_reg <= 4'h0;
      warm_reg <= 3'h0;
    end
    else
    begin
      st_meta_reg <= pin_st;
      st_sync_reg <= st_meta_reg;
      ttl_meta_reg <= pin_ttl;
      ttl_sync_reg <= ttl_meta_reg;
      prev_reg <= pick;
      warm_reg <= {warm_reg[1:0], 1'b1};
    end
  end

  // Select per pin after synchronising; a switch can itself cause a false edge
  assign pick = (thresh_sel & st_sync_reg) | (~thresh_sel & ttl_sync_reg);

  // No edges until prev_reg holds a real sample, so reset cannot fake one
  assign primed = warm_reg[2];
  assign level = pick;
  assign rise = {NPINS{primed}} & ~prev_reg & pick;
  assign fall = {NPINS{primed}} & prev_reg & ~pick;
endmodule : pin_edge_detect

// ### design/port_pins_pkg.sv
// Constants for the four-pin port with change detection
package port_pins_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int NPINS = 4;
  localparam int PIN3 = 3;
  // Register offsets
  localparam logic [3:0] OFF_LEVEL = 4'h0;
  localparam logic [3:0] OFF_DIR = 4'h1;
  localparam logic [3:0] OFF_PULLUP = 4'h2;
  localparam logic [3:0] OFF_THRESH = 4'h3;
  localparam logic [3:0] OFF_RISE_EN = 4'h4;
  localparam logic [3:0] OFF_FALL_EN = 4'h5;
  localparam logic [3:0] OFF_FLAG = 4'h6;
  localparam logic [3:0] OFF_CTRL = 4'h7;
  localparam logic [3:0] OFF_IRQ_MASK = 4'h8;
  // Control register fields
  localparam int CTRL_IRQ_EN_BIT = 0;
  localparam int CTRL_PULLUP_N_BIT = 1;
  localparam int CTRL_SUMMARY_BIT = 7;
  // Reset values
  localparam logic [3:0] DIR_RESET = 4'hF;
  localparam logic [3:0] PULLUP_RESET = 4'hF;
  localparam logic [3:0] THRESH_RESET = 4'hF;
  localparam logic [3:0] EDGE_EN_RESET = 4'h0;
  localparam logic [3:0] IRQ_MASK_RESET = 4'hF;
  localparam logic CTRL_IRQ_EN_RESET = 1'b0;
  localparam logic CTRL_PULLUP_N_RESET = 1'b1;
  // Implemented bits on the small package: pin 3 only
  localparam logic [3:0] SMALL_PKG_MASK = 4'h8;
  localparam logic [3:0] LARGE_PKG_MASK = 4'hF;
endpackage : port_pins_pkg

// ### design/port_pins_with_change_detect.sv
// Four-pin port with pin muxing, pull-ups and change interrupt
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module port_pins_with_change_detect
  import port_pins_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Static configuration
  input wire logic large_package,
  input wire logic master_clear_input_fuse_enable,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Pad inputs at both thresholds
  input wire logic [NPINS-1:0] pin_st_in,
  input wire logic [NPINS-1:0] pin_ttl_in,
  // Pad drive for pins 2 to 0, pull-up for all four pins
  output logic [NPINS-2:0] pin_out,
  output logic [NPINS-2:0] pin_oe,
  output logic [NPINS-1:0] pin_pullup_on,
  // Peripheral outputs
  input wire logic capture_compare_unit3_en,
  input wire logic capture_compare_unit3_out,
  input wire logic switch_controller3_out_a_en,
  input wire logic switch_controller3_out_a,
  input wire logic switch_controller3_out_b_en,
  input wire logic switch_controller3_out_b,
  input wire logic [NPINS-2:0] port_latch,
  // Input functions and status
  output logic [NPINS-1:0] pin_level,
  output logic master_clear_req,
  output logic change_irq_summary_flag,
  output logic irq
);
  logic [2:0] dir_reg;
  logic [NPINS-1:0] pullup_reg;
  logic [NPINS-1:0] thresh_reg;
  logic [NPINS-1:0] rise_en_reg;
  logic [NPINS-1:0] fall_en_reg;
  logic [NPINS-1:0] flag_reg;
  logic [NPINS-1:0] flag_next;
  logic [NPINS-1:0] mask_reg;
  logic irq_en_reg;
  logic pullup_n_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic irq_reg;
  logic master_clear_input_reg;
  logic [NPINS-1:0] level;
  logic [NPINS-1:0] rise;
  logic [NPINS-1:0] fall;
  logic [DATA_W-1:0] rd_mux;

  // Register map, one byte per offset, data in bits 3 to 0 except at 0x7:
  //   0x0 pin levels after the selected threshold, read only
  //   0x1 direction, one makes the pin an input; bit 3 is fixed at one
  //   0x2 weak pull-up enable per pin
  //   0x3 threshold select, one picks Schmitt, zero picks TTL
  //   0x4 rising edge enable per pin
  //   0x5 falling edge enable per pin
  //   0x6 change flags, writing zero clears, writing one leaves alone
  //   0x7 control: bit 0 master enable, bit 1 global pull-up enable
  //       (active low), bit 7 summary of all change flags, read only
  //   0x8 interrupt mask per pin, one lets the flag reach the interrupt
  // Any other offset reads zero and ignores writes.
  //
  // Timing seen from the pad:
  //   edges 1 and 2 carry a pad change through the synchroniser,
  //   edge 3 sets the change flag, edge 4 raises the interrupt,
  //   master clear follows pin 3 one edge after its level is seen.
  // The bus never waits: a write lands at its own strobe edge and a read
  // answer stands in reg_rdata for exactly the following cycle.
  //
  // Pad drive:
  //   pin_out, pin_oe and pin_pullup_on are registered, so the pad never
  //   sees a glitch from the select logic, at the cost of one cycle of lag.
  //   Pin 3 has no driver at all; it is sensed only.
  //   An enabled peripheral owns its pin even while the direction bit
  //   says input, which mirrors the fixed output priority of the port.
  //
  // Hazards a user must know:
  //   - Switching a threshold select can itself look like an edge, so the
  //     flag logic cannot tell it from a real pin change.
  //   - Software that clears flags should write back only the bits it has
  //     seen set; a new edge during the write is kept, never lost.
  //   - On the small package pins 2 to 0 do not exist: their direction
  //     reads one, pull-up reads zero and threshold reads one, and they
  //     never drive.
  //   - Edge detection is suppressed for three cycles after reset so the
  //     reset value of the sample history cannot be taken as an edge.
  //   - The summary flag is combinational from the flags, the interrupt
  //     is registered, so the interrupt trails the summary by one cycle.

  // Decode of a write to a given offset
  function automatic logic wr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off,
                                  input logic wr);
    wr_hit = wr && (a == off);
  endfunction : wr_hit

  wire [NPINS-1:0] impl_mask = large_package ? LARGE_PKG_MASK : SMALL_PKG_MASK;
  wire [NPINS-1:0] wd = reg_wdata[NPINS-1:0];
  wire wr_dir = wr_hit(reg_addr, OFF_DIR, reg_wr);
  wire wr_pullup = wr_hit(reg_addr, OFF_PULLUP, reg_wr);
  wire wr_thresh = wr_hit(reg_addr, OFF_THRESH, reg_wr);
  wire wr_rise = wr_hit(reg_addr, OFF_RISE_EN, reg_wr);
  wire wr_fall = wr_hit(reg_addr, OFF_FALL_EN, reg_wr);
  wire wr_flag = wr_hit(reg_addr, OFF_FLAG, reg_wr);
  wire wr_ctrl = wr_hit(reg_addr, OFF_CTRL, reg_wr);
  wire wr_mask = wr_hit(reg_addr, OFF_IRQ_MASK, reg_wr);

  // Effective config: unimplemented direction and threshold bits behave as reset values, pull-up bits as zero
  wire [NPINS-1:0] thresh_eff = (thresh_reg & impl_mask) | (THRESH_RESET & ~impl_mask);
  wire [2:0] dir_eff = dir_reg | ~impl_mask[2:0];
  wire [NPINS-1:0] dir_full = {1'b1, dir_eff};
  wire [NPINS-1:0] pullup_eff = pullup_reg & impl_mask;

  pin_edge_detect u_edge (
    .ref_clk(ref_clk),
    .srst(srst),
    .pin_st(pin_st_in),
    .pin_ttl(pin_ttl_in),
    .thresh_sel(thresh_eff),
    .level(level),
    .rise(rise),
    .fall(fall)
  );

  // Enabled edges; both enables set catch either direction
  wire [NPINS-1:0] hit = (rise & rise_en_reg) | (fall & fall_en_reg);

  // Clear request per pin: a write of zero to the flag register
  wire [NPINS-1:0] clr_req = wr_flag ? ~wd : 4'h0;

  // One flag per pin; a new edge in the same cycle as its clear wins
  genvar p;
  generate
    for (p = 0; p < NPINS; p++)
    begin : g_flag
      assign flag_next[p] = (flag_reg[p] & ~clr_req[p]) | hit[p];
    end
  endgenerate

  // Peripheral enables and values, indexed by pin
  wire [2:0] periph_en = {switch_controller3_out_a_en, switch_controller3_out_b_en,
                          capture_compare_unit3_en};
  wire [2:0] periph_val = {switch_controller3_out_a, switch_controller3_out_b,
                           capture_compare_unit3_out};
  wire [2:0] drv;

  // One selector per driven pin, 2 to 0; an enabled peripheral beats the port latch
  genvar q;
  generate
    for (q = 0; q < NPINS - 1; q++)
    begin : g_drive_sel
      assign drv[q] = periph_en[q] ? periph_val[q] : port_latch[q];
    end
  endgenerate

  // Peripheral ownership overrides the direction bit
  wire [2:0] drive = (~dir_eff | periph_en) & impl_mask[2:0];
  wire [NPINS-1:0] out_full = {1'b0, drive};

  // Pull-up only with global enable low and pin not driving
  wire [NPINS-1:0] pu_next = pullup_eff & ~out_full & {NPINS{~pullup_n_reg}};

  wire summary = |flag_reg;
  wire [NPINS-1:0] pend = flag_reg & mask_reg;

  // Interrupt and master clear requests ahead of their output registers
  wire irq_next = irq_en_reg && (|pend);
  // Master clear is active low on pin 3
  wire master_clear_input_next = master_clear_input_fuse_enable && !level[PIN3];

  // Read mux; unmapped offsets read zero
  always_comb
  begin
    case (reg_addr)
      OFF_LEVEL: rd_mux = {4'h0, level};
      OFF_DIR: rd_mux = {4'h0, dir_full};
      OFF_PULLUP: rd_mux = {4'h0, pullup_eff};
      OFF_THRESH: rd_mux = {4'h0, thresh_eff};
      OFF_RISE_EN: rd_mux = {4'h0, rise_en_reg};
      OFF_FALL_EN: rd_mux = {4'h0, fall_en_reg};
      OFF_FLAG: rd_mux = {4'h0, flag_reg};
      OFF_CTRL: rd_mux = {summary, 5'h00, pullup_n_reg, irq_en_reg};
      OFF_IRQ_MASK: rd_mux = {4'h0, mask_reg};
      default: rd_mux = 8'h00;
    endcase
  end

  // Direction for pins 2 to 0; pin 3 has no storage and reads as one
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      dir_reg <= DIR_RESET[2:0];
    else if (wr_dir)
      dir_reg <= wd[2:0];
  end

  // Pull-up enables; the pad sees them only through pu_next
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      pullup_reg <= PULLUP_RESET;
    else if (wr_pullup)
      pullup_reg <= wd;
  end

  // Threshold selects; changing one may fake an edge on that pin
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      thresh_reg <= THRESH_RESET;
    else if (wr_thresh)
      thresh_reg <= wd;
  end

  // Rising edge enables, kept apart from falling so both can be set
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      rise_en_reg <= EDGE_EN_RESET;
    else if (wr_rise)
      rise_en_reg <= wd;
  end

  // Falling edge enables
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      fall_en_reg <= EDGE_EN_RESET;
    else if (wr_fall)
      fall_en_reg <= wd;
  end

  // Interrupt mask; a masked flag still sets and still shows in the summary
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      mask_reg <= IRQ_MASK_RESET;
    else if (wr_mask)
      mask_reg <= wd;
  end

  // Control bits; the summary bit is derived, never stored
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      irq_en_reg <= CTRL_IRQ_EN_RESET;
      pullup_n_reg <= CTRL_PULLUP_N_RESET;
    end
    else if (wr_ctrl)
    begin
      irq_en_reg <= reg_wdata[CTRL_IRQ_EN_BIT];
      pullup_n_reg <= reg_wdata[CTRL_PULLUP_N_BIT];
    end
  end

  // Flags, interrupt, read data and registered pin controls
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      flag_reg <= 4'h0;
      irq_reg <= 1'b0;
      rdata_reg <= 8'h00;
      pin_out <= 3'h0;
      pin_oe <= 3'h0;
      pin_pullup_on <= 4'h0;
      master_clear_input_reg <= 1'b0;
    end
    else
    begin
      flag_reg <= flag_next;
      irq_reg <= irq_next;
      rdata_reg <= reg_rd ? rd_mux : 8'h00;
      pin_out <= drv;
      pin_oe <= drive;
      pin_pullup_on <= pu_next;
      master_clear_input_reg <= master_clear_input_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign pin_level = level;
  assign master_clear_req = master_clear_input_reg;
  assign change_irq_summary_flag = summary;
  assign irq = irq_reg;
endmodule : port_pins_with_change_detect

// ### verif/pin_pad_model.sv
// Pad model: wire level of each pin from all its drivers
`timescale 1ns/1ps
module pin_pad_model
  import port_pins_pkg::*;
(
  // Clock and far side sources
  input wire logic ref_clk,
  input wire logic [NPINS-1:0] ext_drive,
  input wire logic [NPINS-1:0] ext_level,
  input wire logic [NPINS-1:0] ttl_split,
  // Device drive and pad sense
  input wire logic [NPINS-2:0] pin_out,
  input wire logic [NPINS-2:0] pin_oe,
  input wire logic [NPINS-1:0] pin_pullup_on,
  output logic [NPINS-1:0] pin_st_in,
  output logic [NPINS-1:0] pin_ttl_in
);
  logic [NPINS-1:0] wander = 4'h0;
  logic [NPINS-1:0] oe;
  logic [NPINS-1:0] lvl;
  // A floating pin toggles so a stale level never looks driven
  always @(posedge ref_clk) wander <= ~wander;
  // Device drive, then far side, then pull-up; Schmitt sense sees the wire, TTL sense flips it where ttl_split is set
  assign oe = {1'b0, pin_oe};
  assign lvl = (oe & {1'b0, pin_out}) | (~oe & ext_drive & ext_level)
    | (~oe & ~ext_drive & (pin_pullup_on | wander));
  assign pin_st_in = lvl;
  assign pin_ttl_in = lvl ^ ttl_split;  // Mid-rail level splits the thresholds
endmodule : pin_pad_model

// ### verif/port_pins_properties.sv
// Checker for port drive, bus read slot and change flag timing
`timescale 1ns/1ps
module port_pins_properties
  import port_pins_pkg::*;
(
  // Clock, reset and straps
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic large_package,
  input wire logic master_clear_input_fuse_enable,
  // Bus, pins and status
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic [NPINS-2:0] pin_out,
  input wire logic [NPINS-2:0] pin_oe,
  input wire logic [NPINS-1:0] pin_pullup_on,
  input wire logic [NPINS-1:0] pin_level,
  input wire logic master_clear_req,
  input wire logic change_irq_summary_flag,
  input wire logic irq,
  // Peripheral outputs
  input wire logic capture_compare_unit3_en,
  input wire logic capture_compare_unit3_out,
  input wire logic switch_controller3_out_a_en,
  input wire logic switch_controller3_out_a,
  input wire logic switch_controller3_out_b_en,
  input wire logic switch_controller3_out_b
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Bus answers, pull-ups and flag timing
  chk_rdata_slot: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  chk_pullup_output: assert property ((pin_oe & pin_pullup_on[2:0]) == 3'h0)
    else $error("pull-up on a driven pin");
  chk_irq_needs_flag: assert property (irq |-> $past(change_irq_summary_flag))
    else $error("interrupt without a flag");
  chk_flag_needs_edge: assert property ($rose(change_irq_summary_flag)
    |-> $past(pin_level) != $past(pin_level, 2))
    else $error("flag set without a pin edge");
  chk_clear_quiet: assert property ((!master_clear_input_fuse_enable || pin_level[3]) [*2]
    |-> !master_clear_req)
    else $error("master clear without cause");
  // Peripheral output beats the port bit on its pin
  chk_prio_pin0: assert property (large_package && capture_compare_unit3_en
    |=> pin_oe[0] && pin_out[0] == $past(capture_compare_unit3_out))
    else $error("pin 0 not driven by capture unit");
  chk_prio_pin1: assert property (large_package && switch_controller3_out_b_en
    |=> pin_oe[1] && pin_out[1] == $past(switch_controller3_out_b))
    else $error("pin 1 not driven by output B");
  chk_prio_pin2: assert property (large_package && switch_controller3_out_a_en
    |=> pin_oe[2] && pin_out[2] == $past(switch_controller3_out_a))
    else $error("pin 2 not driven by output A");
  cover property (irq);
  cover property (master_clear_req);
  cover property (capture_compare_unit3_en && switch_controller3_out_a_en);
endmodule : port_pins_properties

bind port_pins_with_change_detect port_pins_properties i_props (.ref_clk, .srst,
  .large_package, .master_clear_input_fuse_enable, .reg_rd, .reg_rdata, .pin_out, .pin_oe, .pin_pullup_on,
  .pin_level, .master_clear_req, .change_irq_summary_flag, .irq, .capture_compare_unit3_en,
  .capture_compare_unit3_out, .switch_controller3_out_a_en, .switch_controller3_out_a,
  .switch_controller3_out_b_en, .switch_controller3_out_b);

// ### verif/port_pins_with_change_detect_bench.sv
// Self-checking bench for the port pins block
`timescale 1ns/1ps
module port_pins_with_change_detect_bench
  import port_pins_pkg::*;
;
  logic ref_clk = 1'b0, srst = 1'b1, large_package = 1'b1, master_clear_input_fuse_enable = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, rd_seen = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [3:0] ext_drive = 4'hF, ext_level = 4'hF, ttl_split = 4'h0;
  logic [3:0] pin_st_in, pin_ttl_in, pin_pullup_on, pin_level;
  logic [2:0] pin_out, pin_oe, port_latch = 3'h0;
  logic [5:0] periph = 6'h00;
  logic master_clear_req, change_irq_summary_flag, irq;
  logic [31:0] lfsr = 32'hBECB79C2;
  logic [11:0] reset_tab [9] = '{12'h10F, 12'h20F, 12'h30F, 12'h400, 12'h500, 12'h600,
    12'h702, 12'h80F, 12'hF00};
  logic [7:0] exp_q [$];
  int fail_count = 0;
  int samples_checked = 0;
  always #2 ref_clk = ~ref_clk;
  port_pins_with_change_detect i_dut (.ref_clk, .srst, .large_package, .master_clear_input_fuse_enable,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pin_st_in, .pin_ttl_in, .pin_out,
    .pin_oe, .pin_pullup_on, .capture_compare_unit3_en(periph[0]),
    .capture_compare_unit3_out(periph[1]), .switch_controller3_out_a_en(periph[2]),
    .switch_controller3_out_a(periph[3]), .switch_controller3_out_b_en(periph[4]),
    .switch_controller3_out_b(periph[5]), .port_latch, .pin_level, .master_clear_req,
    .change_irq_summary_flag, .irq);
  pin_pad_model i_pads (.ref_clk, .ext_drive, .ext_level, .ttl_split, .pin_out, .pin_oe,
    .pin_pullup_on, .pin_st_in, .pin_ttl_in);
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop
  // Read data stand only in the cycle after the strobe, so look mid-cycle
  always @(posedge ref_clk) rd_seen <= reg_rd;
  always @(negedge ref_clk)
    if (rd_seen)
      check(reg_rdata, exp_q.pop_front());
  // Watchdog at 5000 cycles, well beyond the fewer than two hundred cycles the sequence needs
  initial
  begin
    #20000;
    fail_count++;
    report_and_stop();
  end
  // Main sequence
  initial
  begin
    tick(16);
    srst <= 1'b0;
    foreach (reset_tab[i]) rd(reset_tab[i][11:8], reset_tab[i][7:0]);
    wr(OFF_LEVEL, 8'hF0);
    rd(OFF_LEVEL, 8'h0F);
    ext_drive <= 4'h8;
    wr(OFF_DIR, 8'h00);
    rd(OFF_DIR, 8'h08);
    @(negedge ref_clk);
    check({5'h00, pin_oe}, 8'h07);
    tick(1);
    ttl_split <= 4'h8;
    wr(OFF_THRESH, 8'h07);
    tick(4);
    rd(OFF_LEVEL, 8'h00);
    wr(OFF_THRESH, 8'h0F);
    ttl_split <= 4'h0;
    wr(OFF_RISE_EN, 8'h08);
    wr(OFF_CTRL, 8'h01);
    ext_level <= 4'h0;
    tick(4);
    rd(OFF_FLAG, 8'h00);
    ext_level <= 4'h8;
    tick(4);
    rd(OFF_CTRL, 8'h81);
    @(negedge ref_clk);
    check({7'h00, irq}, 8'h01);
    check({7'h00, change_irq_summary_flag}, 8'h01);
    check({4'h0, pin_pullup_on}, 8'h08);
    wr(OFF_FLAG, 8'h00);
    wr(OFF_IRQ_MASK, 8'h00);
    wr(OFF_FALL_EN, 8'h08);
    ext_level <= 4'h0;
    tick(4);
    rd(OFF_FLAG, 8'h08);
    @(negedge ref_clk);
    check({7'h00, irq}, 8'h00);
    wr(OFF_IRQ_MASK, 8'h0F);
    wr(OFF_CTRL, 8'h00);
    wr(OFF_RISE_EN, 8'h09);
    ext_level <= 4'h8;
    tick(1);
    wr(OFF_FLAG, 8'h00);
    rd(OFF_FLAG, 8'h08);
    wr(OFF_FLAG, 8'h00);
    ext_level <= 4'h0;
    port_latch <= 3'h1;
    tick(4);
    rd(OFF_FLAG, 8'h09);
    @(negedge ref_clk);
    check({5'h00, pin_out}, 8'h01);
    check({7'h00, irq}, 8'h00);
    master_clear_input_fuse_enable <= 1'b1;
    tick(4);
    @(negedge ref_clk);
    check({7'h00, master_clear_req}, 8'h01);
    tick(1);
    master_clear_input_fuse_enable <= 1'b0;
    // Random peripheral enables and values fight the port latch
    repeat (40)
    begin
      tick(1);
      lfsr <= lfsr_next(lfsr);
      periph <= lfsr[5:0];
      port_latch <= lfsr[8:6];
    end
    tick(1);
    periph <= 6'h00;
    large_package <= 1'b0;
    tick(2);
    rd(OFF_DIR, 8'h0F);
    rd(OFF_PULLUP, 8'h08);
    tick(2);
    report_and_stop();
  end
endmodule : port_pins_with_change_detect_bench
